// ===== bench/nlmc_ctrl_chk.sv
`timescale 1ns/1ps
module nlmc_chk (
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  // Requests
  input wire [7:0] node_id,
  input wire cpu_start,
  input wire [27:0] cpu_addr,
  input wire rem_start,
  input wire [19:0] rem_addr,
  // Answers
  input wire cpu_busy_ff,
  input wire rem_busy_ff,
  input wire cpu_rvalid_ff,
  input wire rem_rvalid_ff,
  input wire sw_fwd_ff,
  input wire [27:0] sw_fwd_addr_ff,
  input wire ras_ff,
  input wire cas_ff,
  input wire [9:0] dram_addr_ff,
  input wire irq_req_ff,
  input wire [2:0] irq_ipl_ff
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire busy = cpu_busy_ff || rem_busy_ff;
  a_col_next: assert property (busy |=> cas_ff && ras_ff)
    else $error("column strobe missing");
  a_row_first: assert property (busy |-> ras_ff &&
    dram_addr_ff == ($past(rem_start) ? $past(rem_addr[9:0]) :
    $past(cpu_addr[9:0]))) else $error("row bad");
  a_abort_nocas: assert property
    (ras_ff && !cas_ff && !busy |=> !cas_ff)
    else $error("column strobe on abort");
  a_cas_pulse: assert property (cas_ff |=> !cas_ff)
    else $error("column strobe too long");
  a_read_third: assert property (cpu_rvalid_ff |-> $past(cas_ff))
    else $error("read data late or early");
  a_rem_read: assert property (rem_rvalid_ff |-> $past(cas_ff))
    else $error("remote read timing");
  a_fwd_remote: assert property (sw_fwd_ff |-> sw_fwd_addr_ff ==
    $past(cpu_addr) && $past(cpu_addr[27:20]) != node_id) else $error("fwd");
  a_local_stay: assert property ($past(cpu_start) &&
    $past(cpu_addr[27:20]) == node_id |-> !sw_fwd_ff) else $error("local fwd");
  a_irq_level: assert property (irq_req_ff |-> irq_ipl_ff == 3'h6)
    else $error("wrong priority");
  a_busy_one: assert property (cpu_busy_ff |=> !cpu_busy_ff)
    else $error("busy too long");
  c_cpu_read: cover property (cpu_rvalid_ff);
  c_rem_read: cover property (rem_rvalid_ff);
  c_forward: cover property (sw_fwd_ff);
  c_parity_irq: cover property (irq_req_ff);
endmodule // nlmc_chk
bind nlmc_ctrl nlmc_chk u_chk (.clk_sys, .rst_n, .node_id, .cpu_start,
  .cpu_addr, .rem_start, .rem_addr, .cpu_busy_ff, .rem_busy_ff,
  .cpu_rvalid_ff, .rem_rvalid_ff, .sw_fwd_ff, .sw_fwd_addr_ff, .ras_ff,
  .cas_ff, .dram_addr_ff, .irq_req_ff, .irq_ipl_ff);

// ===== bench/nlmc_sw_model.sv
`timescale 1ns/1ps
module nlmc_sw_model (
  // Clock and command
  input wire clk_sys,
  input wire go,
  input wire [1:0] op,
  input wire [19:0] addr,
  input wire [31:0] wdata,
  // Remote request
  output reg rem_start,
  output reg [19:0] rem_addr,
  output reg [1:0] rem_op,
  output reg [31:0] rem_wdata
);
  reg [1:0] age;
  initial begin
    rem_start = 1'b0;
    rem_addr = 20'h0;
    rem_op = 2'h0;
    rem_wdata = 32'h0;
    age = 2'h3;
  end
  always @(negedge clk_sys) begin
    rem_start <= go;
    age <= go ? 2'h0 : (age == 2'h3 ? age : age + 2'h1);
    if (go) begin
      rem_addr <= addr;
      rem_op <= op;
      rem_wdata <= wdata;
    end else if (age == 2'h1) begin
      // Stale lines must not look valid
      rem_addr <= ~rem_addr;
      rem_wdata <= ~rem_wdata;
    end
  end
endmodule // nlmc_sw_model

// ===== bench/node_local_memory_controller_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done = checks_done + 1; \
  if ((a) !== (b)) begin bad_count = bad_count + 1; \
  $display("unexpected t=%0t %h %h", $time, a, b); end end
module node_local_memory_controller_tb;
  reg clk_sys = 1'b0;
  reg rst_n = 1'b0;
  reg cpu_start = 1'b0;
  reg [27:0] cpu_addr = 28'h0;
  reg [1:0] cpu_op = 2'h0;
  reg [1:0] cpu_lane = 2'h0;
  reg cpu_is_mem = 1'b0;
  reg [31:0] cpu_wdata = 32'h0;
  reg go = 1'b0;
  reg [1:0] g_op = 2'h0;
  reg [31:0] g_data = 32'h0;
  reg irq_ack = 1'b0;
  wire [2:0] irq_ipl_ff;
  wire [1:0] sw_fwd_op_ff, sw_fwd_lane_ff;
  wire [31:0] sw_fwd_wdata_ff;
  wire rem_start, cpu_busy_ff, cpu_rvalid_ff, sw_fwd_ff, rem_busy_ff;
  wire rem_rvalid_ff, ras_ff, cas_ff, irq_req_ff;
  wire [19:0] rem_addr;
  wire [1:0] rem_op;
  wire [31:0] rem_wdata, cpu_rdata_ff, rem_rdata_ff;
  wire [27:0] sw_fwd_addr_ff;
  integer bad_count = 0;
  integer checks_done = 0;
  integer cyc = 0;
  integer fwd_n = 0;
  localparam [7:0] NODE = 8'h05;
  always #12.5 clk_sys = ~clk_sys;
  nlmc_sw_model u_sw (.clk_sys(clk_sys), .go(go), .op(g_op),
    .addr(20'h00003), .wdata(g_data), .rem_start(rem_start),
    .rem_addr(rem_addr), .rem_op(rem_op), .rem_wdata(rem_wdata));
  nlmc_ctrl #(.ARRAY_DEPTH(16)) u_dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .node_id(NODE), .cpu_start(cpu_start), .cpu_addr(cpu_addr),
    .cpu_op(cpu_op), .cpu_lane(cpu_lane), .cpu_is_mem(cpu_is_mem),
    .cpu_wdata(cpu_wdata), .cpu_busy_ff(cpu_busy_ff),
    .cpu_rvalid_ff(cpu_rvalid_ff), .cpu_rdata_ff(cpu_rdata_ff),
    .sw_fwd_ff(sw_fwd_ff), .sw_fwd_addr_ff(sw_fwd_addr_ff),
    .sw_fwd_op_ff(sw_fwd_op_ff), .sw_fwd_lane_ff(sw_fwd_lane_ff),
    .sw_fwd_wdata_ff(sw_fwd_wdata_ff), .rem_start(rem_start),
    .rem_addr(rem_addr), .rem_op(rem_op), .rem_lane(2'h0),
    .rem_wdata(rem_wdata), .rem_busy_ff(rem_busy_ff),
    .rem_rvalid_ff(rem_rvalid_ff), .rem_rdata_ff(rem_rdata_ff),
    .ras_ff(ras_ff), .cas_ff(cas_ff), .dram_addr_ff(),
    .irq_req_ff(irq_req_ff), .irq_ipl_ff(irq_ipl_ff), .irq_ack(irq_ack));
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (sw_fwd_ff === 1'b1) fwd_n = fwd_n + 1;
    if (cyc == 2000) begin
      bad_count = bad_count + 1;
      test_done;
    end
  end
  task test_done;
    begin
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  // One cpu reference; read data is due two edges after accept
  task acc(input [1:0] op, input [1:0] ln, input [27:0] a,
    input [31:0] d, input m);
    begin
      @(negedge clk_sys);
      cpu_start = 1'b1;
      cpu_op = op;
      cpu_lane = ln;
      cpu_addr = a;
      cpu_wdata = d;
      cpu_is_mem = m;
      @(negedge clk_sys);
      cpu_start = 1'b0;
      repeat (2) @(negedge clk_sys);
      `CHK(cpu_rvalid_ff, (op == 2'h0 && m && a[27:20] == NODE))
    end
  endtask
  task t_local;
    begin
      acc(2'h1, 2'h0, {NODE, 20'h00003}, 32'hdeadbeef, 1'b1);
      acc(2'h0, 2'h0, {NODE, 20'h00003}, 32'h0, 1'b1);
      `CHK(cpu_rdata_ff, 32'hdeadbeef)
      acc(2'h2, 2'h2, {NODE, 20'h00003}, 32'h0000005a, 1'b1);
      acc(2'h0, 2'h0, {NODE, 20'h00003}, 32'h0, 1'b1);
      `CHK(cpu_rdata_ff, 32'hde5abeef)
      `CHK(irq_req_ff, 1'b0)
      `CHK(fwd_n, 0)
      $display("local test done");
    end
  endtask
  task t_abort_fwd;
    begin
      acc(2'h1, 2'h0, {NODE, 20'h00003}, 32'h0, 1'b0);
      acc(2'h0, 2'h0, {NODE, 20'h00003}, 32'h0, 1'b1);
      `CHK(cpu_rdata_ff, 32'hde5abeef)
      acc(2'h1, 2'h1, {8'h09, 20'h00007}, 32'h0badf00d, 1'b1);
      `CHK(fwd_n, 1)
      `CHK(sw_fwd_addr_ff, {8'h09, 20'h00007})
      `CHK(sw_fwd_op_ff, 2'h1)
      `CHK(sw_fwd_lane_ff, 2'h1)
      `CHK(sw_fwd_wdata_ff, 32'h0badf00d)
      $display("abort and forward test done");
    end
  endtask
  task t_remote;
    begin
      g_op <= 2'h1;
      g_data <= 32'h12345678;
      go <= 1'b1;
      @(negedge clk_sys);
      go <= 1'b0;
      repeat (6) @(negedge clk_sys);
      acc(2'h0, 2'h0, {NODE, 20'h00003}, 32'h0, 1'b1);
      `CHK(cpu_rdata_ff, 32'h12345678)
      g_op <= 2'h0;
      go <= 1'b1;
      @(negedge clk_sys);
      go <= 1'b0;
      repeat (6) @(negedge clk_sys);
      `CHK(rem_rdata_ff, 32'h12345678)
      $display("remote test done");
    end
  endtask
  task t_parity;
    begin
      // Only a flipped stored bit can make a bad word
      u_dut.u_array.g_lane[0].mem[3] = 9'h178;
      acc(2'h0, 2'h0, {NODE, 20'h00003}, 32'h0, 1'b1);
      `CHK(cpu_rdata_ff, 32'h12345678)
      `CHK(irq_req_ff, 1'b1)
      `CHK(irq_ipl_ff, 3'h6)
      irq_ack = 1'b1;
      @(negedge clk_sys);
      irq_ack = 1'b0;
      `CHK(irq_req_ff, 1'b0)
      `CHK(irq_ipl_ff, 3'h0)
      $display("parity test done");
    end
  endtask
  initial begin
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    t_local;
    t_abort_fwd;
    t_remote;
    t_parity;
    test_done;
  end
endmodule // node_local_memory_controller_tb

// ===== rtl/nlmc_array.v
`timescale 1ns/1ps
`include "nlmc_defines.vh"
module nlmc_array #(
  parameter LANES = 4,
  parameter LANE_W = 8,
  parameter AW = 20,
  parameter DEPTH = 1024
) (
  // Clock
  input wire clk_sys,
  // Access
  input wire [AW-1:0] addr,
  input wire we,
  input wire [LANES-1:0] lane_en,
  input wire [LANES*(LANE_W+1)-1:0] wdata,
  output wire [LANES*(LANE_W+1)-1:0] rdata
);
  // Each lane is eight data and one parity bit; DEPTH shrinks it for sim
  localparam LW = LANE_W + 1;
  localparam IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  wire [IW-1:0] idx;
  assign idx = addr[IW-1:0];
  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : g_lane
      reg [LW-1:0] mem [0:DEPTH-1];
      always @(posedge clk_sys) begin
        if (we && lane_en[g]) begin
          mem[idx] <= wdata[g*LW +: LW];
        end
      end
      assign rdata[g*LW +: LW] = mem[idx];
    end
  endgenerate
endmodule // nlmc_array

// ===== rtl/nlmc_ctrl.v
`timescale 1ns/1ps
`include "nlmc_defines.vh"
// Behaviour
// (RULE1) A reference whose node field matches the node id is served locally.
// (RULE2) A reference with a different node field is forwarded to the switch.
// (RULE3) Local processor and switch-side remote requests both reach the bank.
// (RULE4) A local access takes three cycles, latching address and op first.
// (RULE5) Write data is captured in cycle two, freeing the bus in cycle three.
// (RULE6) Read data returns in the third cycle, the bus idle in the second.
// (RULE7) The array is four byte lanes of eight data bits plus one parity bit.
// (RULE8) A 10-bit row from low address bits is strobed, then a 10-bit column.
// (RULE9) Row strobe begins as soon as a reference starts, before decode.
// (RULE10) A reference decoded as non-memory aborts with no column strobe.
// (RULE11) Every write stores one computed parity bit with each byte.
// (RULE12) Every read rechecks parity; a mismatch requests a level 6 interrupt.
// (RULE13) A byte write changes only the addressed lane and its parity.
module nlmc_ctrl #(
  parameter NODE_W = `NLMC_NODE_W,
  parameter ADDR_W = `NLMC_ADDR_W,
  parameter ARRAY_DEPTH = 1024
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  // Own node number
  input wire [NODE_W-1:0] node_id,
  // Local processor request
  input wire cpu_start,
  input wire [ADDR_W-1:0] cpu_addr,
  input wire [1:0] cpu_op,
  input wire [1:0] cpu_lane,
  input wire cpu_is_mem,
  input wire [31:0] cpu_wdata,
  output reg cpu_busy_ff,
  output reg cpu_rvalid_ff,
  output reg [31:0] cpu_rdata_ff,
  // Forward to switch
  output reg sw_fwd_ff,
  output reg [ADDR_W-1:0] sw_fwd_addr_ff,
  output reg [1:0] sw_fwd_op_ff,
  output reg [1:0] sw_fwd_lane_ff,
  output reg [31:0] sw_fwd_wdata_ff,
  // Remote request arriving from switch
  input wire rem_start,
  input wire [19:0] rem_addr,
  input wire [1:0] rem_op,
  input wire [1:0] rem_lane,
  input wire [31:0] rem_wdata,
  output reg rem_busy_ff,
  output reg rem_rvalid_ff,
  output reg [31:0] rem_rdata_ff,
  // DRAM strobes
  output reg ras_ff,
  output reg cas_ff,
  output reg [9:0] dram_addr_ff,
  // Parity interrupt
  output reg irq_req_ff,
  output reg [2:0] irq_ipl_ff,
  input wire irq_ack
);
  localparam ST_IDLE = 3'b001;
  localparam ST_DATA = 3'b010;
  localparam ST_LAST = 3'b100;
  localparam LANES = `NLMC_LANES;
  localparam LW = `NLMC_LANE_W;
  localparam SW = LANES * (LW + 1);

  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg src_rem_ff;
  reg [1:0] op_ff;
  reg [1:0] lane_ff;
  reg [19:0] waddr_ff;

  wire [NODE_W-1:0] cpu_node;
  wire cpu_local;
  wire rem_go;
  wire cpu_go;
  wire go;
  wire [19:0] go_addr;
  wire [3:0] lane_en;
  wire [3:0] wpar;
  wire [3:0] rpar;
  wire [SW-1:0] arr_wdata;
  wire [SW-1:0] arr_rdata;
  wire [31:0] rd_bytes;
  wire [3:0] rd_stored;
  wire par_err;
  wire arr_we;

  assign cpu_node = cpu_addr[`NLMC_NODE_LSB +: NODE_W];
  assign cpu_local = (cpu_node == node_id); // RULE1
  // Remote requests win an idle slot; cpu retries while busy
  assign rem_go = (state_ff == ST_IDLE) && rem_start; // RULE3
  assign cpu_go = (state_ff == ST_IDLE) && !rem_start && cpu_start &&
                  cpu_local && cpu_is_mem; // RULE10
  assign go = rem_go || cpu_go;
  assign go_addr = rem_go ? rem_addr : cpu_addr[19:0];

  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (go) begin
          nxt_state = ST_DATA;
        end
      end
      ST_DATA: nxt_state = ST_LAST;
      ST_LAST: nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  // Write data lands in the second cycle
  wire [31:0] wd_now;
  assign wd_now = src_rem_ff ? rem_wdata : cpu_wdata; // RULE5
  wire [31:0] wd_byte;
  assign wd_byte = {4{wd_now[7:0]}};
  wire [31:0] wd_sel;
  assign wd_sel = (op_ff == `NLMC_OP_BYTE) ? wd_byte : wd_now;

  nlmc_parity #(.LANES(LANES), .LANE_W(LW)) u_wpar (
    .data(wd_sel),
    .par(wpar)
  );

  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : g_pack
      assign arr_wdata[g*(LW+1) +: LW+1] = // RULE11 RULE7
        {wpar[g], wd_sel[g*LW +: LW]};
      assign rd_bytes[g*LW +: LW] = arr_rdata[g*(LW+1) +: LW];
      assign rd_stored[g] = arr_rdata[g*(LW+1) + LW];
      assign lane_en[g] = (op_ff == `NLMC_OP_WORD) ||
                          (lane_ff == g); // RULE13
    end
  endgenerate

  assign arr_we = (state_ff == ST_DATA) && (op_ff != `NLMC_OP_READ);

  nlmc_array #(.LANES(LANES), .LANE_W(LW), .AW(20),
               .DEPTH(ARRAY_DEPTH)) u_array (
    .clk_sys(clk_sys),
    .addr(waddr_ff),
    .we(arr_we),
    .lane_en(lane_en),
    .wdata(arr_wdata),
    .rdata(arr_rdata)
  );

  nlmc_parity #(.LANES(LANES), .LANE_W(LW)) u_rpar (
    .data(rd_bytes),
    .par(rpar)
  );
  assign par_err = (rpar != rd_stored);

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      src_rem_ff <= 1'b0;
      op_ff <= `NLMC_OP_READ;
      lane_ff <= 2'h0;
      waddr_ff <= 20'h00000;
      cpu_busy_ff <= 1'b0;
      cpu_rvalid_ff <= 1'b0;
      cpu_rdata_ff <= 32'h00000000;
      rem_busy_ff <= 1'b0;
      rem_rvalid_ff <= 1'b0;
      rem_rdata_ff <= 32'h00000000;
      sw_fwd_ff <= 1'b0;
      sw_fwd_addr_ff <= {ADDR_W{1'b0}};
      sw_fwd_op_ff <= 2'h0;
      sw_fwd_lane_ff <= 2'h0;
      sw_fwd_wdata_ff <= 32'h00000000;
      ras_ff <= 1'b0;
      cas_ff <= 1'b0;
      dram_addr_ff <= 10'h000;
      irq_req_ff <= 1'b0;
      irq_ipl_ff <= 3'h0;
    end else begin
      state_ff <= nxt_state;
      cpu_rvalid_ff <= 1'b0;
      rem_rvalid_ff <= 1'b0;
      sw_fwd_ff <= 1'b0;
      cas_ff <= 1'b0;
      // Row strobe on any start, ahead of the decode result
      if (state_ff == ST_IDLE && (rem_start || cpu_start)) begin
        ras_ff <= 1'b1; // RULE9
        dram_addr_ff <= rem_start ? rem_addr[`NLMC_ROW_LSB +: 10] :
                        cpu_addr[`NLMC_ROW_LSB +: 10]; // RULE8
      end else if (state_ff == ST_IDLE) begin
        // Refused start never leaves idle, so its row pulse lapses here
        ras_ff <= 1'b0; // RULE10
      end
      if (go) begin
        src_rem_ff <= rem_go;
        op_ff <= rem_go ? rem_op : cpu_op; // RULE4
        lane_ff <= rem_go ? rem_lane : cpu_lane;
        waddr_ff <= go_addr;
        cpu_busy_ff <= cpu_go;
        rem_busy_ff <= rem_go;
      end
      // Off-node reference goes out through the switch
      if (state_ff == ST_IDLE && !rem_start && cpu_start && !cpu_local) begin
        sw_fwd_ff <= 1'b1; // RULE2
        sw_fwd_addr_ff <= cpu_addr;
        sw_fwd_op_ff <= cpu_op;
        sw_fwd_lane_ff <= cpu_lane;
        sw_fwd_wdata_ff <= cpu_wdata;
      end
      if (state_ff == ST_DATA) begin
        cas_ff <= 1'b1;
        dram_addr_ff <= waddr_ff[`NLMC_COL_LSB +: 10]; // RULE8
        cpu_busy_ff <= 1'b0;
        rem_busy_ff <= 1'b0;
      end
      if (state_ff == ST_LAST) begin
        ras_ff <= 1'b0;
        if (op_ff == `NLMC_OP_READ) begin
          if (src_rem_ff) begin
            rem_rvalid_ff <= 1'b1; // RULE6
            rem_rdata_ff <= rd_bytes;
          end else begin
            cpu_rvalid_ff <= 1'b1; // RULE6
            cpu_rdata_ff <= rd_bytes;
          end
        end
      end
      // Set beats acknowledge in the same cycle
      if (state_ff == ST_LAST && op_ff == `NLMC_OP_READ && par_err) begin
        irq_req_ff <= 1'b1; // RULE12
        irq_ipl_ff <= `NLMC_PAR_IPL;
      end else if (irq_ack) begin
        irq_req_ff <= 1'b0;
        irq_ipl_ff <= 3'h0;
      end
    end
  end
endmodule // nlmc_ctrl

// ===== rtl/nlmc_defines.vh
`ifndef NLMC_DEFINES_VH
`define NLMC_DEFINES_VH
// Operation codes
`define NLMC_OP_READ 2'h0
`define NLMC_OP_WORD 2'h1
`define NLMC_OP_BYTE 2'h2
// Geometry
`define NLMC_LANES 4
`define NLMC_LANE_W 8
`define NLMC_DRAM_AW 10
`define NLMC_NODE_W 8
// Word address: row low 10 bits, column next 10, node id above
`define NLMC_ROW_LSB 0
`define NLMC_COL_LSB 10
`define NLMC_NODE_LSB 20
`define NLMC_ADDR_W 28
// Interrupt priority for a parity fault
`define NLMC_PAR_IPL 3'h6
// Cycles per local access
`define NLMC_ACC_CYC 3
`endif

// ===== rtl/nlmc_parity.v
`timescale 1ns/1ps
module nlmc_parity #(
  parameter LANES = 4,
  parameter LANE_W = 8
) (
  // Data in
  input wire [LANES*LANE_W-1:0] data,
  // Even parity per byte lane
  output wire [LANES-1:0] par
);
  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : g_lane
      assign par[g] = ^data[g*LANE_W +: LANE_W];
    end
  endgenerate
endmodule // nlmc_parity
